//--- hdl/puds_pkg.sv
// Shared constants, register map and types of the PCI user data steering block
package puds_pkg;
   // Widths
   localparam int DATA_W      = 32;
   localparam int CMD_W       = 4;
   localparam int APB_AW      = 12;
   localparam int COUNT_W     = 16;
   localparam int REGION_LSB  = 12;
   localparam int BUF_DEPTH   = 2;
   localparam int NUM_REGIONS = 2;

   // Bus commands, decoded active high
   localparam logic [CMD_W-1:0] CMD_CFG_READ  = 4'ha;
   localparam int               CMD_WRITE_BIT = 0;

   // Register byte offsets
   localparam logic [APB_AW-1:0] REG_CTRL      = 12'h000;
   localparam logic [APB_AW-1:0] REG_INI_ADDR  = 12'h004;
   localparam logic [APB_AW-1:0] REG_INI_COUNT = 12'h008;
   localparam logic [APB_AW-1:0] REG_STATUS    = 12'h00c;
   localparam logic [APB_AW-1:0] REG_BASE0     = 12'h010;
   localparam logic [APB_AW-1:0] REG_BASE_STEP = 12'h004;

   // Field positions
   localparam int CTRL_TGT_EN_BIT    = 0;
   localparam int CTRL_INI_START_BIT = 1;
   localparam int STAT_TGT_DATA_BIT  = 0;
   localparam int STAT_INI_BUSY_BIT  = 1;
   localparam int STAT_BUF_FULL_BIT  = 2;
   localparam int STAT_BUF_VALID_BIT = 3;

   // Reset values and the count decrement step
   localparam logic [DATA_W-1:0]  WORD_RESET  = 32'h0000_0000;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE   = 16'h0001;

   // One sample of the bus pins
   typedef struct packed {
      logic              frameN;
      logic              irdyN;
      logic              trdyN;
      logic [CMD_W-1:0]  cbeN;
      logic [DATA_W-1:0] ad;
   } puds_pins_t;

   localparam puds_pins_t PINS_IDLE = '{frameN: 1'b1, irdyN: 1'b1, trdyN: 1'b1,
                                        cbeN: 4'hf, ad: 32'h0000_0000};

   typedef enum logic [1:0] {TGT_IDLE, TGT_ADDR, TGT_DATA} puds_tgt_state_t;
   typedef enum logic [1:0] {INI_IDLE, INI_ADDR, INI_DATA} puds_ini_state_t;
endpackage : puds_pkg

//--- hdl/puds_buffer.sv
// Small FIFO with valid/ready on both sides for captured words
`timescale 1ns/1ps
module puds_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Fill side
   input  wire logic             inValid,
   output      logic             inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output      logic             outValid,
   input  wire logic             outReady,
   output      logic [WIDTH-1:0] outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_ff   [DEPTH];
   logic [WIDTH-1:0] nxt_mem  [DEPTH];
   logic [PW-1:0]    wrPtr_ff;
   logic [PW-1:0]    nxt_wrPtr;
   logic [PW-1:0]    rdPtr_ff;
   logic [PW-1:0]    nxt_rdPtr;
   logic [CW-1:0]    count_ff;
   logic [CW-1:0]    nxt_count;
   logic             push;
   logic             pop;

   assign inReady  = (count_ff != CNT_FULL);
   assign outValid = (count_ff != '0);
   assign outData  = mem_ff[rdPtr_ff];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_entry
         always_comb begin
            nxt_mem[g] = (push && (wrPtr_ff == PW'(g))) ? inData : mem_ff[g];
         end
         always_ff @(posedge clk) begin
            mem_ff[g] <= nxt_mem[g];
         end
      end
   endgenerate

   always_comb begin
      nxt_wrPtr = wrPtr_ff;
      nxt_rdPtr = rdPtr_ff;
      nxt_count = count_ff;
      if (push) begin
         nxt_wrPtr = (wrPtr_ff == PTR_LAST) ? '0 : PW'(wrPtr_ff + 1'b1);
      end
      if (pop) begin
         nxt_rdPtr = (rdPtr_ff == PTR_LAST) ? '0 : PW'(rdPtr_ff + 1'b1);
      end
      if (push && !pop) begin
         nxt_count = CW'(count_ff + 1'b1);
      end else if (pop && !push) begin
         nxt_count = CW'(count_ff - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
      end
   end
endmodule : puds_buffer

//--- hdl/puds_steering.sv
// Core-side data steering: target and initiator data states, strobe and data paths
`timescale 1ns/1ps
// Summary of operation
// - Region match pulses exactly one cycle
// - Target direction high write, held per transaction
// - Target data flag follows data state
// - Write data stable while strobe high
// - Strobe needs both ready signals
// - User-enabled bus data driven to pins in non-config target reads and initiator writes
// - Initiator data flag follows data state
// - Strobe needs readies low and data state
module puds_steering
   import puds_pkg::*;
#(
   parameter int NREG = puds_pkg::NUM_REGIONS
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   // APB slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [puds_pkg::APB_AW-1:0]   paddr,
   input  wire logic [puds_pkg::DATA_W-1:0]   pwdata,
   output      logic [puds_pkg::DATA_W-1:0]   prdata,
   output      logic                          pready,
   output      logic                          pslverr,
   // Bus pins
   input  wire logic                          pciFrameN,
   input  wire logic                          pciIrdyN,
   input  wire logic                          pciTrdyN,
   input  wire logic [puds_pkg::CMD_W-1:0]    pciCbeN,
   input  wire logic [puds_pkg::DATA_W-1:0]   pciAdIn,
   output      logic [puds_pkg::DATA_W-1:0]   pciAdOut,
   output      logic                          pciAdOe,
   output      logic                          pciFrameOutN,
   output      logic                          pciWaitReq,
   // Target flags to user logic
   output      logic [NREG-1:0]               regionMatchPulse,
   output      logic                          targetWriteDir,
   output      logic                          targetDataState,
   output      logic                          configReadCmdLine,
   output      logic                          addrPhaseValid,
   // Initiator flags
   input  wire logic                          initiatorWriteDir,
   output      logic                          initiatorAddrPhase,
   output      logic                          initiatorDataState,
   // Shared data
   output      logic                          transferDoneStrobe,
   output      logic [puds_pkg::DATA_W-1:0]   internalSharedBus,
   input  wire logic [puds_pkg::DATA_W-1:0]   userBusData,
   input  wire logic                          userBusOeN,
   // Captured word stream
   output      logic [puds_pkg::DATA_W-1:0]   captureData,
   output      logic                          captureValid,
   input  wire logic                          captureReady
);
   import puds_pkg::*;

   puds_pins_t        pinS1_ff, pinS2_ff, pinsIn;
   logic              framePrev_ff;
   puds_tgt_state_t   tgt_ff, nxt_tgt;
   puds_ini_state_t   ini_ff, nxt_ini;
   logic [DATA_W-1:0] tgtAddr_ff, nxt_tgtAddr;
   logic [CMD_W-1:0]  tgtCmd_ff, nxt_tgtCmd;
   logic [NREG-1:0]   match_ff, nxt_match, hit;
   logic [COUNT_W-1:0] iniLeft_ff, nxt_iniLeft;
   logic [DATA_W-1:0] adOut_ff, nxt_adOut;
   logic              adOe_ff, nxt_adOe;
   logic              ctrlTgtEn_ff, nxt_ctrlTgtEn;
   logic              iniStart_ff, nxt_iniStart;
   logic [DATA_W-1:0] iniAddr_ff, nxt_iniAddr;
   logic [COUNT_W-1:0] iniCount_ff, nxt_iniCount;
   logic [DATA_W-1:0] base_ff [NREG];
   logic [DATA_W-1:0] nxt_base [NREG];
   logic [DATA_W-1:0] prdata_ff, nxt_prdata;
   logic              slverr_ff, nxt_slverr;
   logic              frameFall, strobe, capturePush, bufInReady, supplying;
   logic              apbWrite, apbSetup;
   logic [DATA_W-1:0] status;

   // Every pin passes two flops before any logic looks at it
   assign pinsIn = '{frameN: pciFrameN, irdyN: pciIrdyN, trdyN: pciTrdyN,
                     cbeN: pciCbeN, ad: pciAdIn};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinS1_ff     <= PINS_IDLE;
         pinS2_ff     <= PINS_IDLE;
         framePrev_ff <= 1'b1;
      end else begin
         pinS1_ff     <= pinsIn;
         pinS2_ff     <= pinS1_ff;
         framePrev_ff <= pinS2_ff.frameN;
      end
   end

   assign frameFall = framePrev_ff && !pinS2_ff.frameN;
   assign strobe = !pinS2_ff.irdyN && !pinS2_ff.trdyN
                   && ((tgt_ff == TGT_DATA) || (ini_ff == INI_DATA));

   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_region
         assign hit[g] = ctrlTgtEn_ff && (tgt_ff == TGT_ADDR)
                         && (tgtAddr_ff[DATA_W-1:REGION_LSB] == base_ff[g][DATA_W-1:REGION_LSB]);
      end
   endgenerate

   // Target state machine and address-phase latch
   always_comb begin
      nxt_tgt     = tgt_ff;
      nxt_tgtAddr = tgtAddr_ff;
      nxt_tgtCmd  = tgtCmd_ff;
      nxt_match   = '0;
      case (tgt_ff)
         TGT_IDLE: begin
            if (frameFall) begin
               nxt_tgt     = TGT_ADDR;
               nxt_tgtAddr = pinS2_ff.ad;
               nxt_tgtCmd  = ~pinS2_ff.cbeN;
            end
         end
         TGT_ADDR: begin
            nxt_match = hit;
            nxt_tgt   = (|hit) ? TGT_DATA : TGT_IDLE;
         end
         TGT_DATA: begin
            // Last phase completes, or the master left without a transfer
            if (pinS2_ff.frameN && (strobe || pinS2_ff.irdyN)) begin
               nxt_tgt = TGT_IDLE;
            end
         end
         default: nxt_tgt = TGT_IDLE;
      endcase
   end

   // Initiator state machine, counts completed phases
   always_comb begin
      nxt_ini     = ini_ff;
      nxt_iniLeft = iniLeft_ff;
      case (ini_ff)
         INI_IDLE: begin
            if (iniStart_ff && (iniCount_ff != COUNT_RESET)) begin
               nxt_ini     = INI_ADDR;
               nxt_iniLeft = iniCount_ff;
            end
         end
         INI_ADDR: nxt_ini = INI_DATA;
         INI_DATA: begin
            if (strobe) begin
               nxt_iniLeft = COUNT_W'(iniLeft_ff - COUNT_ONE);
               if (iniLeft_ff == COUNT_ONE) begin
                  nxt_ini = INI_IDLE;
               end
            end
         end
         default: nxt_ini = INI_IDLE;
      endcase
   end

   // Outgoing data: address in address phase, else what the user enabled
   assign supplying = ((tgt_ff == TGT_DATA) && !tgtCmd_ff[CMD_WRITE_BIT]
                       && (tgtCmd_ff != CMD_CFG_READ))
                      || ((ini_ff == INI_DATA) && initiatorWriteDir);

   always_comb begin
      nxt_adOut = (ini_ff == INI_ADDR) ? iniAddr_ff : userBusData;
      nxt_adOe  = (ini_ff == INI_ADDR) || (!userBusOeN && supplying);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tgt_ff     <= TGT_IDLE;
         ini_ff     <= INI_IDLE;
         tgtAddr_ff <= WORD_RESET;
         tgtCmd_ff  <= '0;
         match_ff   <= '0;
         iniLeft_ff <= COUNT_RESET;
         adOut_ff   <= WORD_RESET;
         adOe_ff    <= 1'b0;
      end else begin
         tgt_ff     <= nxt_tgt;
         ini_ff     <= nxt_ini;
         tgtAddr_ff <= nxt_tgtAddr;
         tgtCmd_ff  <= nxt_tgtCmd;
         match_ff   <= nxt_match;
         iniLeft_ff <= nxt_iniLeft;
         adOut_ff   <= nxt_adOut;
         adOe_ff    <= nxt_adOe;
      end
   end

   // Words taken from the bus go into the buffer; a full buffer asks for wait states
   assign capturePush = strobe && (((tgt_ff == TGT_DATA) && tgtCmd_ff[CMD_WRITE_BIT])
                                   || ((ini_ff == INI_DATA) && !initiatorWriteDir));

   puds_buffer #(
      .WIDTH (DATA_W),
      .DEPTH (BUF_DEPTH)
   ) u_capture (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .inValid  (capturePush),
      .inReady  (bufInReady),
      .inData   (pinS2_ff.ad),
      .outValid (captureValid),
      .outReady (captureReady),
      .outData  (captureData)
   );

   // APB register file, zero wait states
   assign apbWrite = psel && penable && pwrite;
   assign apbSetup = psel && !penable;

   always_comb begin
      status = WORD_RESET;
      status[STAT_TGT_DATA_BIT]  = (tgt_ff == TGT_DATA);
      status[STAT_INI_BUSY_BIT]  = (ini_ff != INI_IDLE);
      status[STAT_BUF_FULL_BIT]  = !bufInReady;
      status[STAT_BUF_VALID_BIT] = captureValid;
   end

   always_comb begin
      nxt_ctrlTgtEn = ctrlTgtEn_ff;
      nxt_iniStart  = 1'b0;
      nxt_iniAddr   = iniAddr_ff;
      nxt_iniCount  = iniCount_ff;
      nxt_prdata    = prdata_ff;
      nxt_slverr    = slverr_ff;
      for (int i = 0; i < NREG; i++) begin
         nxt_base[i] = base_ff[i];
      end
      if (apbWrite) begin
         case (paddr)
            REG_CTRL: begin
               nxt_ctrlTgtEn = pwdata[CTRL_TGT_EN_BIT];
               nxt_iniStart  = pwdata[CTRL_INI_START_BIT];
            end
            REG_INI_ADDR:  nxt_iniAddr  = pwdata;
            REG_INI_COUNT: nxt_iniCount = pwdata[COUNT_W-1:0];
            default: ;
         endcase
         for (int i = 0; i < NREG; i++) begin
            if (paddr == APB_AW'(REG_BASE0 + REG_BASE_STEP * i)) begin
               nxt_base[i] = pwdata;
            end
         end
      end
      // Read data and error are prepared in the setup cycle
      if (apbSetup) begin
         nxt_prdata = WORD_RESET;
         nxt_slverr = 1'b0;
         case (paddr)
            REG_CTRL:      nxt_prdata[CTRL_TGT_EN_BIT] = ctrlTgtEn_ff;
            REG_INI_ADDR:  nxt_prdata = iniAddr_ff;
            REG_INI_COUNT: nxt_prdata[COUNT_W-1:0] = iniCount_ff;
            REG_STATUS:    nxt_prdata = status;
            default:       nxt_slverr = 1'b1;
         endcase
         for (int i = 0; i < NREG; i++) begin
            if (paddr == APB_AW'(REG_BASE0 + REG_BASE_STEP * i)) begin
               nxt_prdata = base_ff[i];
               nxt_slverr = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrlTgtEn_ff <= 1'b0;
         iniStart_ff  <= 1'b0;
         iniAddr_ff   <= WORD_RESET;
         iniCount_ff  <= COUNT_RESET;
         prdata_ff    <= WORD_RESET;
         slverr_ff    <= 1'b0;
         for (int i = 0; i < NREG; i++) begin
            base_ff[i] <= WORD_RESET;
         end
      end else begin
         ctrlTgtEn_ff <= nxt_ctrlTgtEn;
         iniStart_ff  <= nxt_iniStart;
         iniAddr_ff   <= nxt_iniAddr;
         iniCount_ff  <= nxt_iniCount;
         prdata_ff    <= nxt_prdata;
         slverr_ff    <= nxt_slverr;
         for (int i = 0; i < NREG; i++) begin
            base_ff[i] <= nxt_base[i];
         end
      end
   end

   // Outputs
   assign prdata             = prdata_ff;
   assign pready             = 1'b1;
   assign pslverr            = slverr_ff && psel && penable;
   assign pciAdOut           = adOut_ff;
   assign pciAdOe            = adOe_ff;
   assign pciFrameOutN       = (ini_ff == INI_IDLE);
   assign pciWaitReq         = !bufInReady;
   assign regionMatchPulse   = match_ff;
   assign targetWriteDir     = tgtCmd_ff[CMD_WRITE_BIT];
   assign targetDataState    = (tgt_ff == TGT_DATA);
   assign configReadCmdLine  = (tgtCmd_ff == CMD_CFG_READ);
   assign addrPhaseValid     = frameFall;
   assign initiatorAddrPhase = (ini_ff == INI_ADDR);
   assign initiatorDataState = (ini_ff == INI_DATA);
   assign transferDoneStrobe = strobe;
   // Same pipeline stage as the strobe, so data holds while it is high
   assign internalSharedBus  = pinS2_ff.ad;
endmodule : puds_steering

//--- verif/puds_steering_sva.sv
// Port-level assertions for the steering block
`timescale 1ns/1ps
module puds_steering_sva
   import puds_pkg::*;
#(
   parameter int NREG = 2
) (
   // Clock and reset
   input wire logic                        clk,
   input wire logic                        sys_rst,
   // Bus pins
   input wire logic                        pciIrdyN,
   input wire logic                        pciTrdyN,
   input wire logic [puds_pkg::DATA_W-1:0] pciAdIn,
   input wire logic [puds_pkg::DATA_W-1:0] pciAdOut,
   input wire logic                        pciAdOe,
   // Flags and data
   input wire logic [NREG-1:0]             regionMatchPulse,
   input wire logic                        targetWriteDir,
   input wire logic                        targetDataState,
   input wire logic                        configReadCmdLine,
   input wire logic                        initiatorAddrPhase,
   input wire logic                        initiatorDataState,
   input wire logic                        transferDoneStrobe,
   input wire logic [puds_pkg::DATA_W-1:0] internalSharedBus,
   input wire logic [puds_pkg::DATA_W-1:0] userBusData,
   input wire logic                        userBusOeN
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_match_single: assert property ((|regionMatchPulse) |=> !(|regionMatchPulse))
      else $error("match pulse longer than one cycle");
   a_dir_held: assert property (targetDataState && $past(targetDataState)
      |-> $stable(targetWriteDir)) else $error("target direction changed inside a transaction");
   a_data_on_hit: assert property ((|regionMatchPulse) == $rose(targetDataState))
      else $error("target data state not entered with the match pulse");
   a_bus_stable: assert property (transferDoneStrobe
      |-> internalSharedBus == $past(pciAdIn, 2))
      else $error("shared bus does not hold the transferred word");
   a_strobe_ready: assert property (transferDoneStrobe
      |-> !$past(pciIrdyN, 2) && !$past(pciTrdyN, 2))
      else $error("strobe without both ready signals");
   a_ad_follows: assert property ($past(targetDataState) && !$past(targetWriteDir)
      && !$past(configReadCmdLine) && !$past(userBusOeN)
      |-> pciAdOe && pciAdOut == $past(userBusData))
      else $error("enabled user word not driven to the pins");
   a_ini_data: assert property (initiatorAddrPhase |=> initiatorDataState && !initiatorAddrPhase)
      else $error("initiator data state does not follow the address phase");
   a_strobe_state: assert property (transferDoneStrobe == (!$past(pciIrdyN, 2)
      && !$past(pciTrdyN, 2) && (targetDataState || initiatorDataState)))
      else $error("strobe does not match readies and data state");
endmodule : puds_steering_sva

//--- verif/puds_user_model.sv
// Behavioural user application on the far side of the internal bus
`timescale 1ns/1ps
module puds_user_model
   import puds_pkg::*;
#(
   parameter logic [31:0] SRC_WORD = 32'h5a5a_c3c3
) (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   // Flags from the core
   input  wire logic                        matchPulse,
   input  wire logic                        targetWriteDir,
   input  wire logic                        targetDataState,
   input  wire logic                        configReadCmdLine,
   input  wire logic                        initiatorDataState,
   input  wire logic                        transferDoneStrobe,
   input  wire logic [puds_pkg::DATA_W-1:0] internalSharedBus,
   // Bench controls
   input  wire logic                        iniWrite,
   input  wire logic                        stall,
   // Toward the core
   output      logic                        initiatorWriteDir,
   output      logic                        captureReady,
   output      logic [puds_pkg::DATA_W-1:0] userBusData,
   output      logic                        userBusOeN,
   output      logic [puds_pkg::DATA_W-1:0] heldWord_ff
);
   import puds_pkg::*;
   // One decode set shared by all regions keeps the model small
   logic              writeSel_ff, nxt_writeSel, readEnN_ff, nxt_readEnN, iniDir_ff, captureEnable;
   logic [DATA_W-1:0] nxt_heldWord;

   always_comb begin
      nxt_writeSel = (matchPulse && targetWriteDir) || (targetDataState && writeSel_ff);
      nxt_readEnN = !((matchPulse && !targetWriteDir) || (targetDataState && !readEnN_ff));
      captureEnable = (writeSel_ff && transferDoneStrobe)
         || (!iniDir_ff && initiatorDataState && transferDoneStrobe);
      nxt_heldWord = captureEnable ? internalSharedBus : heldWord_ff;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         writeSel_ff <= 1'b0;
         readEnN_ff <= 1'b1;
         iniDir_ff <= 1'b0;
         heldWord_ff <= '0;
      end else begin
         writeSel_ff <= nxt_writeSel;
         readEnN_ff <= nxt_readEnN;
         iniDir_ff <= iniWrite;
         heldWord_ff <= nxt_heldWord;
      end
   end

   assign initiatorWriteDir = iniDir_ff;
   assign captureReady = !stall;
   // Merged active-low enable
   assign userBusOeN = !((iniDir_ff && initiatorDataState) || (!readEnN_ff && !configReadCmdLine));
   // Released bus shows the inverse so a stale word never looks valid
   assign userBusData = userBusOeN ? ~SRC_WORD : SRC_WORD;
endmodule : puds_user_model

//--- verif/test_puds_steering.sv
// Self-checking bench for the steering block
`timescale 1ns/1ps
module test_puds_steering;
   import puds_pkg::*;
   localparam logic [31:0] SRC = 32'h5a5a_c3c3;
   logic              clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, pciAdOut, isb, userData, capData, heldWord;
   logic [DATA_W-1:0] lastOut, firstOut;
   logic              pready, pslverr, pciAdOe, frameOutN, waitReq, tgtWr, tgtData, cfgRd;
   logic              addrVld, iniDir, iniAddr, iniData, strobe, userOeN, capValid, capReady;
   logic              iniWrite = 1'b0, stall = 1'b0, hitDir;
   logic [1:0]        match, hitMask;
   puds_pins_t        pins = PINS_IDLE;
   int                err_total = 0, compares = 0, strobes, oeSeen, hits;
   logic [31:0]       popped[$];

   always #12.5 clk = ~clk;

   puds_steering u_puds_steering (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pciFrameN(pins.frameN & frameOutN), .pciIrdyN(pins.irdyN),
      .pciTrdyN(pins.trdyN), .pciCbeN(pins.cbeN), .pciAdIn(pciAdOe ? pciAdOut : pins.ad),
      .pciAdOut(pciAdOut), .pciAdOe(pciAdOe), .pciFrameOutN(frameOutN), .pciWaitReq(waitReq),
      .regionMatchPulse(match), .targetWriteDir(tgtWr), .targetDataState(tgtData),
      .configReadCmdLine(cfgRd), .addrPhaseValid(addrVld), .initiatorWriteDir(iniDir),
      .initiatorAddrPhase(iniAddr), .initiatorDataState(iniData), .transferDoneStrobe(strobe),
      .internalSharedBus(isb), .userBusData(userData), .userBusOeN(userOeN),
      .captureData(capData), .captureValid(capValid), .captureReady(capReady));

   puds_user_model u_puds_user_model (.clk(clk), .sys_rst(sys_rst), .matchPulse(|match),
      .targetWriteDir(tgtWr), .targetDataState(tgtData), .configReadCmdLine(cfgRd),
      .initiatorDataState(iniData), .transferDoneStrobe(strobe), .internalSharedBus(isb),
      .iniWrite(iniWrite), .stall(stall), .initiatorWriteDir(iniDir), .captureReady(capReady),
      .userBusData(userData), .userBusOeN(userOeN), .heldWord_ff(heldWord));

   always @(posedge clk) begin
      if (strobe === 1'b1) strobes++;
      if ((|match) === 1'b1) begin
         hits++;
         hitMask |= match;
         hitDir = tgtWr;
      end
      if (pciAdOe === 1'b1) begin
         if (oeSeen == 0) firstOut = pciAdOut;
         lastOut = pciAdOut;
         oeSeen++;
      end
      if (capValid === 1'b1 && capReady === 1'b1) popped.push_back(capData);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic clear;
      strobes = 0;
      oeSeen = 0;
      hits = 0;
      hitMask = 2'b00;
      popped.delete();
   endtask : clear

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic drive(input logic f, input logic r, input logic [3:0] c, input logic [31:0] a);
      @(posedge clk);
      pins <= '{frameN: f, irdyN: r, trdyN: r, cbeN: c, ad: a};
   endtask : drive

   // Address, six wait states, n data phases, then idle
   task automatic tgt_cycle(input logic [3:0] cmd, input logic [31:0] a, input int n);
      clear();
      drive(1'b0, 1'b1, ~cmd, a);
      repeat (6) drive(1'b0, 1'b1, 4'h0, a);
      for (int i = 0; i < n; i++) drive(i == n - 1, 1'b0, 4'h0, 32'hc0de_0000 + i);
      repeat (8) drive(1'b1, 1'b1, 4'hf, 32'h0);
   endtask : tgt_cycle

   task automatic ini_cycle(input logic wr, input int n);
      logic [31:0] rd;
      logic        er;
      clear();
      @(posedge clk);
      iniWrite <= wr;
      apb(1'b1, REG_INI_ADDR, 32'habcd_0000, rd, er);
      apb(1'b1, REG_INI_COUNT, n, rd, er);
      apb(1'b1, REG_CTRL, 32'h3, rd, er);
      repeat (6) drive(1'b1, 1'b1, 4'hf, 32'h0);
      for (int i = 0; i < n; i++) drive(1'b1, 1'b0, 4'h0, 32'h7700_0000 + i);
      repeat (8) drive(1'b1, 1'b1, 4'hf, 32'h0);
   endtask : ini_cycle

   task automatic t_regs;
      logic [31:0] rd;
      logic        er;
      apb(1'b1, REG_BASE0, 32'h1234_5000, rd, er);
      apb(1'b1, REG_BASE0 + REG_BASE_STEP, 32'h0000_7000, rd, er);
      apb(1'b1, REG_CTRL, 32'h1, rd, er);
      apb(1'b0, REG_BASE0, 32'h0, rd, er);
      chk(rd, 32'h1234_5000);
      chk(er, 1'b0);
      apb(1'b0, 12'h100, 32'h0, rd, er);
      chk(rd, 32'h0);
      chk(er, 1'b1);
      $display("test regs done");
   endtask : t_regs

   // Receiver stalls so both words sit in the buffer until released
   task automatic t_tgt_write;
      @(posedge clk);
      stall <= 1'b1;
      tgt_cycle(4'h7, 32'h1234_5010, 2);
      chk(hits, 1);
      chk(hitDir, 1'b1);
      chk(strobes, 2);
      chk(tgtData, 1'b0);
      chk(waitReq, 1'b1);
      chk(heldWord, 32'hc0de_0001);
      @(posedge clk);
      stall <= 1'b0;
      repeat (5) @(posedge clk);
      chk(popped.size(), 2);
      chk(popped[0], 32'hc0de_0000);
      chk(popped[1], 32'hc0de_0001);
      $display("test target write done");
   endtask : t_tgt_write

   task automatic t_tgt_read;
      tgt_cycle(4'h6, 32'h0000_7004, 1);
      chk(hitMask, 2'b10);
      chk(hitDir, 1'b0);
      chk(oeSeen != 0, 1'b1);
      chk(lastOut, SRC);
      chk(strobes, 1);
      chk(pciAdOe, 1'b0);
      $display("test target read done");
   endtask : t_tgt_read

   task automatic t_cfg_read;
      tgt_cycle(4'ha, 32'h1234_5000, 1);
      chk(cfgRd, 1'b1);
      chk(oeSeen, 0);
      $display("test config read done");
   endtask : t_cfg_read

   task automatic t_ini;
      ini_cycle(1'b0, 2);
      chk(firstOut, 32'habcd_0000);
      chk(strobes, 2);
      chk(iniData, 1'b0);
      chk(frameOutN, 1'b1);
      chk(popped.size(), 2);
      chk(heldWord, 32'h7700_0001);
      ini_cycle(1'b1, 1);
      chk(lastOut, SRC);
      chk(strobes, 1);
      chk(popped.size(), 0);
      $display("test initiator done");
   endtask : t_ini

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_tgt_write();
      t_tgt_read();
      t_cfg_read();
      t_ini();
      wrap_up();
   end

   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      wrap_up();
   end
endmodule : test_puds_steering

bind puds_steering puds_steering_sva #(.NREG(NREG)) u_puds_steering_sva (.clk(clk),
   .sys_rst(sys_rst), .pciIrdyN(pciIrdyN), .pciTrdyN(pciTrdyN), .pciAdIn(pciAdIn),
   .pciAdOut(pciAdOut), .pciAdOe(pciAdOe), .regionMatchPulse(regionMatchPulse),
   .targetWriteDir(targetWriteDir), .targetDataState(targetDataState),
   .configReadCmdLine(configReadCmdLine), .initiatorAddrPhase(initiatorAddrPhase),
   .initiatorDataState(initiatorDataState), .transferDoneStrobe(transferDoneStrobe),
   .internalSharedBus(internalSharedBus), .userBusData(userBusData), .userBusOeN(userBusOeN));
